/* File: core/wcs_pkg.sv */
/*
 Package for the word clock sync monitor: timing constants, rate table, states.
 Assumes a 250 MHz ref_clk; all users write wcs_pkg::name.
*/
package wcs_pkg;
	// ==========================================================
	// Clock and counter widths
	localparam int          CLK_HZ        = 250_000_000;
	localparam int          PER_W         = 16;
	localparam int          ACC_W         = 32;
	localparam int          FREQ_W        = 18;
	// ==========================================================
	// Validity window on the measured period (cycles of ref_clk)
	// 28 kHz .. 200 kHz covers single, double and quad rates
	localparam int          MIN_HZ        = 28_000;
	localparam int          MAX_HZ        = 200_000;
	localparam logic [15:0] PER_MIN       = 16'(CLK_HZ / MAX_HZ);
	localparam logic [15:0] PER_MAX       = 16'(CLK_HZ / MIN_HZ);
	// Input considered lost after this many cycles with no edge
	localparam logic [15:0] LOSS_CYC      = 16'(PER_MAX + 16'h0010);
	// Good periods in a row counted before lock; lock sets on the next good period
	localparam logic [2:0]  LOCK_CNT      = 3'h4;
	// ==========================================================
	// Standard rates in Hz
	localparam int          N_RATES       = 7;
	localparam logic [17:0] RATE_HZ [N_RATES] = '{
		18'h07D00, 18'h0AC44, 18'h0BB80, 18'h15888, 18'h17700, 18'h2B110, 18'h2EE00};
	localparam logic [17:0] SINGLE_MAX_HZ = 18'h0BB80;
	localparam logic [17:0] DEFAULT_HZ    = 18'h0BB80;
	// Fractional NCO accumulator width for output clocks
	localparam int          NCO_W         = 32;
	// High rate multiplier for the regenerated clock
	localparam logic [9:0]  HI_MULT       = 10'h200;
	// ==========================================================
	// Reference selection
	typedef enum logic [2:0] {
		WCS_REF_INTERNAL = 3'b001,
		WCS_REF_WORD     = 3'b010,
		WCS_REF_HOLD     = 3'b100
	} wcs_ref_e;
endpackage

/* File: core/wcs_meas_if.sv */
/*
 Interface carrying period measurements from the measuring unit to the monitor top.
 Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
interface wcs_meas_if;
	logic                            edge_seen;
	logic [wcs_pkg::PER_W-1:0]       period;
	logic                            period_ok;
	logic                            lost;
	modport meter (output edge_seen, output period, output period_ok, output lost);
	modport user  (input edge_seen, input period, input period_ok, input lost);
endinterface

/* File: core/wcs_period_meter.sv */
/*
 Period meter: counts ref_clk cycles between rising edges of the word clock input.
 Assumes the word clock input is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module wcs_period_meter (
	input  wire logic   ref_clk,
	input  wire logic   reset,
	input  wire logic   word_clk_in,
	wcs_meas_if.meter   meas
);
	typedef struct packed {
		logic                        prev;
		logic [wcs_pkg::PER_W-1:0]   cnt;
		logic                        edge_seen;
		logic [wcs_pkg::PER_W-1:0]   period;
		logic                        period_ok;
		logic                        lost;
	} wcs_meter_s;

	wcs_meter_s st;
	wcs_meter_s next_st;

	// ==========================================================
	// Edge timing
	always_comb begin
		next_st           = st;
		next_st.prev      = word_clk_in;
		next_st.edge_seen = 1'b0;
		if (word_clk_in && !st.prev) begin
			next_st.edge_seen = 1'b1;
			next_st.period    = st.cnt;
			next_st.period_ok = (st.cnt >= wcs_pkg::PER_MIN) &&
				(st.cnt <= wcs_pkg::PER_MAX);
			next_st.cnt       = 16'h0001;
			next_st.lost      = 1'b0;
		end else if (st.cnt >= wcs_pkg::LOSS_CYC) begin
			next_st.lost      = 1'b1;
			next_st.period_ok = 1'b0;
		end else begin
			next_st.cnt       = st.cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st      <= '0;
			st.lost <= 1'b1;
		end else begin
			st      <= next_st;
		end
	end

	assign meas.edge_seen = st.edge_seen;
	assign meas.period    = st.period;
	assign meas.period_ok = st.period_ok;
	assign meas.lost      = st.lost;
endmodule

/* File: core/wcs_monitor.sv */
/*
 Word clock sync monitor top: lock detect, source selection, frequency report,
 fallback to a standard rate, regenerated word clock and high rate clock outputs.
 Assumes all inputs are synchronous to ref_clk; reset is asynchronous, active high.
*/
`timescale 1ns/1ps
// Overview of operation
// - Lock output rises once a valid word clock has been seen on the input.
// - Word clock is the source only in auto-follow mode with word clock preferred.
// - Active reference status shows word clock once a valid input is present in auto-follow mode with word clock preferred.
// - Measured reference frequency is computed in hardware and reported.
// - On loss of reference the output word clock returns to a valid rate.
// - Filtered period yields a 512x base rate clock, rejecting input jitter.
// - Word clock in and out is a square wave at the sample rate.
// - On reference failure switch to master at the nearest standard rate.
// - Single rate option keeps output word clock between 32 and 48 kHz.
// - Single, double or quad rate input accepted and followed automatically.
module wcs_monitor (
	input  wire logic          ref_clk,
	input  wire logic          reset,
	input  wire logic          word_clk_in,
	input  wire logic          auto_follow_clock_mode,
	input  wire logic          pref_word_clock,
	input  wire logic          single_speed_out,
	input  wire logic [17:0]   master_rate_hz,
	output logic               lock,
	output logic               word_ref_active,
	output logic [2:0]         active_reference_status,
	output logic [17:0]        ref_freq_hz,
	output logic               master_mode,
	output logic               word_clk_out,
	output logic               hi_clk_out
);
	typedef struct packed {
		logic [2:0]                  good;
		logic                        lock;
		logic [2:0]                  ref_sel;
		logic [wcs_pkg::ACC_W-1:0]   filt;
		logic [17:0]                 freq;
		logic [17:0]                 out_hz;
		logic [17:0]                 fall_hz;
		logic                        was_word;
		logic [wcs_pkg::NCO_W-1:0]   wc_acc;
		logic [wcs_pkg::NCO_W-1:0]   hi_acc;
		logic                        wc_out;
		logic                        hi_out;
	} wcs_top_s;

	wcs_top_s   st;
	wcs_top_s   next_st;
	wcs_meas_if meas ();

	// ==========================================================
	// Period meter
	wcs_period_meter u_meter (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.word_clk_in (word_clk_in),
		.meas        (meas)
	);

	// ==========================================================
	// Helpers
	function automatic logic [17:0] nearest_rate(input logic [17:0] hz);
		logic [17:0] best;
		logic [17:0] bd;
		logic [17:0] d;
		best = wcs_pkg::RATE_HZ[0];
		bd   = 18'h3FFFF;
		for (int i = 0; i < wcs_pkg::N_RATES; i++) begin
			d = (hz > wcs_pkg::RATE_HZ[i]) ? hz - wcs_pkg::RATE_HZ[i] : wcs_pkg::RATE_HZ[i] - hz;
			if (d < bd) begin
				bd   = d;
				best = wcs_pkg::RATE_HZ[i];
			end
		end
		return best;
	endfunction

	function automatic logic [17:0] single_rate(input logic [17:0] hz);
		logic [17:0] r;
		r = hz;
		if (r > wcs_pkg::SINGLE_MAX_HZ) begin
			r = r >> 1;
		end
		if (r > wcs_pkg::SINGLE_MAX_HZ) begin
			r = r >> 1;
		end
		return r;
	endfunction

	// ==========================================================
	// Next state scratch
	logic [17:0]             meas_hz;
	logic [17:0]             hi_base;
	logic                    use_word;
	logic [17:0]             tgt_hz;
	logic [wcs_pkg::NCO_W-1:0] wc_inc;
	logic [wcs_pkg::NCO_W-1:0] hi_inc;
	logic [63:0]             wc_prod;
	logic [63:0]             hi_prod;

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		// ==========================================================
		// Lock qualification over consecutive good periods
		if (meas.lost) begin
			next_st.good = 3'h0;
			next_st.lock = 1'b0;
		end else if (meas.edge_seen) begin
			if (!meas.period_ok) begin
				next_st.good = 3'h0;
				next_st.lock = 1'b0;
			end else if (st.good < wcs_pkg::LOCK_CNT) begin
				next_st.good = st.good + 3'h1;
			end else begin
				next_st.lock = 1'b1;
			end
		end

		// ==========================================================
		// Jitter filter on the period, first order, 1/16 weight (16.8 fixed point)
		if (meas.edge_seen && meas.period_ok) begin
			if (!st.lock) begin
				next_st.filt = {8'h00, meas.period, 8'h00};
			end else begin
				next_st.filt = st.filt - (st.filt >> 4) +
					({8'h00, meas.period, 8'h00} >> 4);
			end
		end
		if (st.filt[23:8] == 16'h0000) begin
			meas_hz = 18'h00000;
		end else begin
			meas_hz = 18'(wcs_pkg::CLK_HZ / int'(st.filt[23:8]));
		end
		next_st.freq = st.lock ? nearest_rate(meas_hz) : 18'h00000;

		// ==========================================================
		// Source selection
		use_word = auto_follow_clock_mode && pref_word_clock && st.lock;
		if (use_word) begin
			next_st.ref_sel  = wcs_pkg::WCS_REF_WORD;
			next_st.was_word = 1'b1;
			next_st.fall_hz  = st.freq;
		end else if (st.was_word && auto_follow_clock_mode && pref_word_clock) begin
			next_st.ref_sel  = wcs_pkg::WCS_REF_HOLD;
		end else begin
			next_st.ref_sel  = wcs_pkg::WCS_REF_INTERNAL;
			next_st.was_word = 1'b0;
		end
		case (next_st.ref_sel)
			wcs_pkg::WCS_REF_WORD:     tgt_hz = st.freq;
			wcs_pkg::WCS_REF_HOLD:     tgt_hz = (st.fall_hz == 18'h00000) ?
				wcs_pkg::DEFAULT_HZ : st.fall_hz;
			wcs_pkg::WCS_REF_INTERNAL: tgt_hz = nearest_rate(master_rate_hz);
			default:                   tgt_hz = wcs_pkg::DEFAULT_HZ;
		endcase
		if (tgt_hz == 18'h00000) begin
			tgt_hz = wcs_pkg::DEFAULT_HZ;
		end
		next_st.out_hz = single_speed_out ? single_rate(tgt_hz) : tgt_hz;

		// ==========================================================
		// NCO square waves: increment = f * 2^32 / f_clk
		wc_prod = (64'(st.out_hz) << 32) / 64'(wcs_pkg::CLK_HZ);
		hi_base = single_rate(tgt_hz);
		hi_prod = (64'(hi_base) * 64'(wcs_pkg::HI_MULT) << 32) / 64'(wcs_pkg::CLK_HZ);
		wc_inc  = wc_prod[wcs_pkg::NCO_W-1:0];
		hi_inc  = hi_prod[wcs_pkg::NCO_W-1:0];
		next_st.wc_acc = st.wc_acc + wc_inc;
		next_st.hi_acc = st.hi_acc + hi_inc;
		next_st.wc_out = st.wc_acc[wcs_pkg::NCO_W-1];
		next_st.hi_out = st.hi_acc[wcs_pkg::NCO_W-1];
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st.good     <= 3'h0;
			st.lock     <= 1'b0;
			st.ref_sel  <= wcs_pkg::WCS_REF_INTERNAL;
			st.filt     <= '0;
			st.freq     <= 18'h00000;
			st.out_hz   <= wcs_pkg::DEFAULT_HZ;
			st.fall_hz  <= 18'h00000;
			st.was_word <= 1'b0;
			st.wc_acc   <= '0;
			st.hi_acc   <= '0;
			st.wc_out   <= 1'b0;
			st.hi_out   <= 1'b0;
		end else begin
			st         <= next_st;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lock                    <= 1'b0;
			word_ref_active         <= 1'b0;
			active_reference_status <= wcs_pkg::WCS_REF_INTERNAL;
			ref_freq_hz             <= 18'h00000;
			master_mode             <= 1'b1;
			word_clk_out            <= 1'b0;
			hi_clk_out              <= 1'b0;
		end else begin
			lock                    <= st.lock;
			word_ref_active         <= (st.ref_sel == wcs_pkg::WCS_REF_WORD);
			active_reference_status <= st.ref_sel;
			ref_freq_hz             <= st.freq;
			master_mode             <= (st.ref_sel != wcs_pkg::WCS_REF_WORD);
			word_clk_out            <= st.wc_out;
			hi_clk_out              <= st.hi_out;
		end
	end
endmodule

/* File: verification/wcs_wc_source.sv */
/* Word clock source standing in for the outside studio gear.
 Assumes the bench sets enable and the half period in ref_clk cycles. */
`timescale 1ns/1ps
module wcs_wc_source (
	input  logic        ref_clk,
	input  logic        enable,
	input  logic [15:0] half_cyc,
	output logic        word_clk = 1'b0
);
	logic [15:0] cnt = 16'h0000;
	// ====
	// Sole master of the link, square wave, dead low when stopped
	always @(posedge ref_clk) begin
		cnt <= (!enable || cnt == half_cyc - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
		word_clk <= enable && (word_clk ^ (cnt == half_cyc - 16'h0001));
	end
endmodule

/* File: verification/wcs_checker.sv */
/* Port assertions for the word clock sync monitor.
 Assumes a bind onto wcs_monitor, ports matched by name. */
`timescale 1ns/1ps
module wcs_checker (
	input logic        ref_clk,
	input logic        reset,
	input logic        word_clk_in,
	input logic        auto_follow_clock_mode,
	input logic        pref_word_clock,
	input logic        single_speed_out,
	input logic [17:0] master_rate_hz,
	input logic        lock,
	input logic        word_ref_active,
	input logic [2:0]  active_reference_status,
	input logic [17:0] ref_freq_hz,
	input logic        master_mode,
	input logic        word_clk_out,
	input logic        hi_clk_out
);
	logic [15:0] idle;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ====
	// Cycles since the input last moved
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			idle <= 16'h0000;
		end else begin
			idle <= $changed(word_clk_in) ? 16'h0000 : idle + {15'h0000, ~&idle};
		end
	end
	a_status_onehot: assert property ($onehot(active_reference_status))
		else $error("status not one-hot");
	a_source_gated: assert property (
		(!auto_follow_clock_mode || !pref_word_clock) [*5] |-> !word_ref_active
	) else $error("word source outside mode");
	a_status_word: assert property (
		$rose(lock) && auto_follow_clock_mode && pref_word_clock |->
			##[0:3] active_reference_status == wcs_pkg::WCS_REF_WORD
	) else $error("status not word");
	a_master_drop: assert property (
		$rose(lock) && auto_follow_clock_mode && pref_word_clock |-> ##[0:3] !master_mode
	) else $error("still master on word");
	a_master_fallback: assert property ($fell(lock) |-> ##[0:3] master_mode)
		else $error("no master after loss");
	a_lock_loss: assert property (idle > 16'h2310 |-> !lock)
		else $error("lock without input");
	a_freq_unlocked: assert property (!lock [*5] |-> ref_freq_hz == 18'h00000)
		else $error("freq while unlocked");
	a_freq_range: assert property (
		word_ref_active [*5] |-> ref_freq_hz inside {[18'h07D00:18'h2EE00]}
	) else $error("freq out of range");
endmodule

/* File: verification/word_clock_sync_monitor_test.sv */
/* Bench for the word clock sync monitor.
 Assumes wcs_wc_source and wcs_checker are compiled first. */
`timescale 1ns/1ps
module word_clock_sync_monitor_test;
	logic        ref_clk, reset, word_clk_in, lock, word_ref_active, master_mode;
	logic        auto_follow_clock_mode, pref_word_clock, single_speed_out;
	logic        word_clk_out, hi_clk_out, src_en, wo_q, hi_q;
	logic [17:0] master_rate_hz, ref_freq_hz;
	logic [2:0]  active_reference_status;
	logic [15:0] src_half;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          per, hi_n;

	wcs_monitor DUT (
		.ref_clk                 (ref_clk),
		.reset                   (reset),
		.word_clk_in             (word_clk_in),
		.auto_follow_clock_mode  (auto_follow_clock_mode),
		.pref_word_clock         (pref_word_clock),
		.single_speed_out        (single_speed_out),
		.master_rate_hz          (master_rate_hz),
		.lock                    (lock),
		.word_ref_active         (word_ref_active),
		.active_reference_status (active_reference_status),
		.ref_freq_hz             (ref_freq_hz),
		.master_mode             (master_mode),
		.word_clk_out            (word_clk_out),
		.hi_clk_out              (hi_clk_out)
	);
	wcs_wc_source src (.ref_clk, .enable(src_en), .half_cyc(src_half), .word_clk(word_clk_in));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// ====
	// Edge history and run limit
	always @(negedge ref_clk) begin
		wo_q <= word_clk_out;
		hi_q <= hi_clk_out;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk_vec(input string n, input logic [17:0] e, input logic [17:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_in(input string n, input int lo, input int hi, input int g);
		total_checks++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask
	// Flags are lock, word_ref_active, status, master_mode
	task automatic chk_state(input logic [5:0] e, input logic [17:0] f);
		chk_vec("flags", {12'h000, e},
			{12'h000, lock, word_ref_active, active_reference_status, master_mode});
		chk_vec("ref_freq_hz", f, ref_freq_hz);
	endtask
	// Cycles between two output rises, high rate rises in between
	task automatic out_period();
		per = 0;
		hi_n = 0;
		do @(negedge ref_clk); while (!(word_clk_out === 1'b1 && wo_q === 1'b0) && cyc < 100000);
		do begin
			@(negedge ref_clk);
			per++;
			hi_n += (hi_clk_out === 1'b1 && hi_q === 1'b0) ? 1 : 0;
		end while (!(word_clk_out === 1'b1 && wo_q === 1'b0) && per < 20000);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		auto_follow_clock_mode = 1'b0;
		pref_word_clock = 1'b0;
		single_speed_out = 1'b0;
		master_rate_hz = 18'h2B000;
		src_en = 1'b0;
		src_half = 16'h028B;
		repeat (4) @(negedge ref_clk);
		reset = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk_state(6'h03, 18'h00000);
		out_period();
		chk_in("master period", 1415, 1420, per);
		$display("test reset_master done");
		auto_follow_clock_mode = 1'b1;
		pref_word_clock = 1'b1;
		src_en = 1'b1;
		repeat (7812) @(negedge ref_clk);
		chk_state(6'h34, 18'h2EE00);
		out_period();
		chk_in("quad period", 1300, 1305, per);
		chk_in("hi edges", 126, 130, hi_n);
		single_speed_out = 1'b1;
		out_period();
		out_period();
		chk_in("single period", 5205, 5212, per);
		$display("test quad_lock done");
		src_half = 16'h0516;
		repeat (26400) @(negedge ref_clk);
		chk_state(6'h34, 18'h17700);
		out_period();
		chk_in("single period", 5205, 5212, per);
		single_speed_out = 1'b0;
		out_period();
		out_period();
		chk_in("double period", 2601, 2608, per);
		$display("test double_rate done");
		auto_follow_clock_mode = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk_state(6'h23, 18'h17700);
		auto_follow_clock_mode = 1'b1;
		pref_word_clock = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk_state(6'h23, 18'h17700);
		$display("test source_gate done");
		pref_word_clock = 1'b1;
		src_en = 1'b0;
		repeat (9100) @(negedge ref_clk);
		chk_state(6'h09, 18'h00000);
		out_period();
		chk_in("hold period", 2601, 2608, per);
		$display("test loss_hold done");
		print_verdict();
	end
endmodule

bind wcs_monitor wcs_checker chk (
	.ref_clk                 (ref_clk),
	.reset                   (reset),
	.word_clk_in             (word_clk_in),
	.auto_follow_clock_mode  (auto_follow_clock_mode),
	.pref_word_clock         (pref_word_clock),
	.single_speed_out        (single_speed_out),
	.master_rate_hz          (master_rate_hz),
	.lock                    (lock),
	.word_ref_active         (word_ref_active),
	.active_reference_status (active_reference_status),
	.ref_freq_hz             (ref_freq_hz),
	.master_mode             (master_mode),
	.word_clk_out            (word_clk_out),
	.hi_clk_out              (hi_clk_out)
);
